// File: verification/cal_checker_asserts.sv
`timescale 1ns/10ps
module cal_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mod_tick,
   input wire logic [3:0] result_strobe,
   input wire logic result_ready_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = (paddr[1:0] == 2'h0) &&
      ((paddr < 12'h080) ? (paddr[4:0] <= 5'h14) : (paddr <= 12'h084));
   sequence access;
      psel && penable;
   endsequence
   sequence boundary_tick;
      mod_tick ##2 result_strobe[0];
   endsequence
   chk_no_wait: assert property (access |-> pready)
      else $error("access phase stalled");
   chk_bad_addr: assert property (access |-> pslverr == !mapped)
      else $error("error flag does not match address decode");
   chk_err_only_access: assert property (!(psel && penable) |-> !pslverr)
      else $error("error flag outside access phase");
   chk_prdata_hold: assert property ($changed(prdata) |->
      $past(psel) && !$past(penable) && !$past(pwrite))
      else $error("read data moved without a read setup");
   chk_strobe_cause: assert property (result_strobe[0] |-> $past(mod_tick, 2))
      else $error("result strobe without boundary tick");
   chk_strobe_pulse: assert property (result_strobe[0] |=> !result_strobe[0] [*8])
      else $error("result strobe too long or too close");
   chk_ready_falls: assert property ($fell(result_ready_n) |-> result_strobe != 4'h0)
      else $error("ready fell without a new result");
   chk_ready_rises: assert property ($rose(result_ready_n) |->
      $past(psel) && $past(penable) && !$past(pwrite) && $past(paddr) == 12'h084)
      else $error("ready rose without a status read");
   cover property (boundary_tick);
endmodule : cal_checker

// File: verification/channel_phase_and_calibration_test.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module channel_phase_and_calibration_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mod_tick, result_ready_n, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r0;
   logic [3:0] mod_bits, result_strobe, level;
   int errors = 0;
   int n_checks = 0;
   int gap;
   logic [3:0] sel_t [6] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h5, 4'h5};
   logic [9:0] ph_t [6] = '{10'h064, 10'h39C, 10'h064, 10'h064, 10'h1FF, 10'h200};
   int gap_t [6] = '{62, 64, 126, 200, 1022, 3072};
   channel_phase_and_calibration dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mod_tick(mod_tick), .mod_bits(mod_bits),
      .result_strobe(result_strobe), .result_ready_n(result_ready_n));
   mod_source src (.pclk(pclk), .presetn(presetn), .level(level), .mod_tick(mod_tick),
      .mod_bits(mod_bits));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   task automatic apb(input logic w, input int a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= 12'(a);
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic coeff(input int c, input logic [23:0] off, input logic [23:0] g);
      apb(1'b1, c * 32 + 4, {16'h0000, off[23:8]});
      apb(1'b1, c * 32 + 8, {24'h000000, off[7:0]});
      apb(1'b1, c * 32 + 12, {16'h0000, g[23:8]});
      apb(1'b1, c * 32 + 16, {24'h000000, g[7:0]});
   endtask : coeff
   task automatic windows(input int n);
      repeat (n) begin
         @(posedge pclk);
         while (result_strobe[0] !== 1'b1) @(posedge pclk);
      end
   endtask : windows
   task automatic result(input int c, input logic [31:0] exp);
      apb(1'b0, c * 32 + 20, 32'h0);
      `CHECK(rd, exp)
   endtask : result
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #600000;
      errors++;
      end_of_test();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      level = 4'b0101;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         apb(1'b0, c * 32 + 4, 32'h0);
         `CHECK(rd, 32'h0)
         apb(1'b0, c * 32 + 12, 32'h0);
         `CHECK(rd, 32'h00008000)
         apb(1'b1, c * 32 + 8, 32'(c + 1));
      end
      for (int c = 0; c < 4; c++) begin
         apb(1'b0, c * 32 + 8, 32'h0);
         `CHECK(rd, 32'(c + 1))
         coeff(c, 24'h000000, 24'h800000);
      end
      apb(1'b1, 12'h018, 32'hFF);
      apb(1'b0, 12'h018, 32'h0);
      `CHECK({err, rd}, {1'b1, 32'h0})
      $display("register test done");
      apb(1'b1, 12'h080, 32'h0);
      windows(3);
      result(0, 32'h007FFFFF);
      result(1, 32'hFF800000);
      `CHECK(result_ready_n, 1'b0)
      apb(1'b0, 12'h084, 32'h0);
      `CHECK(rd[4:0], 5'h1F)
      apb(1'b0, 12'h084, 32'h0);
      `CHECK({result_ready_n, rd[4:0]}, 6'h20)
      $display("pass-through test done");
      coeff(0, 24'h000100, 24'h400000);
      coeff(1, 24'hFFFFFF, 24'h800000);
      coeff(2, 24'h000000, 24'h400000);
      coeff(3, 24'h000001, 24'hFFFFFF);
      windows(2);
      result(0, 32'h003FFF7F);
      result(1, 32'hFF800001);
      result(2, 32'h003FFFFF);
      result(3, 32'hFF800000);
      $display("correction test done");
      for (int c = 0; c < 4; c++) coeff(c, 24'h000000, 24'h800000);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h020, 32'h2);
      apb(1'b1, 12'h040, 32'h1);
      windows(3);
      apb(1'b0, 12'h014, 32'h0);
      r0 = rd;
      result(2, r0);
      `CHECK(r0 > 32'h000C0000 && r0 < 32'h00160000, 1'b1)
      apb(1'b0, 12'h034, 32'h0);
      `CHECK(rd[31], 1'b1)
      $display("test signal done");
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h040, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h080, {28'h0, sel_t[i]});
         apb(1'b1, 12'h020, {6'h00, ph_t[i], 16'h0000});
         windows(4);
         gap = 0;
         while (result_strobe[1] !== 1'b1) begin
            @(posedge pclk);
            gap++;
         end
         `CHECK(gap, gap_t[i])
      end
      $display("phase test done");
      end_of_test();
   end
endmodule : channel_phase_and_calibration_test
bind channel_phase_and_calibration cal_checker chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mod_tick(mod_tick),
   .result_strobe(result_strobe), .result_ready_n(result_ready_n));

// File: verification/mod_source.sv
`timescale 1ns/10ps
module mod_source (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] level,
   output logic mod_tick,
   output logic [3:0] mod_bits
);
   // bits are only meaningful on a tick; in between they flip so nothing leans on them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_tick <= 1'b0;
         mod_bits <= 4'h0;
      end else begin
         mod_tick <= !mod_tick;
         mod_bits <= mod_tick ? ~level : level;
      end
   end
endmodule : mod_source

// File: verilog/cal_correct.sv
`timescale 1ns/10ps
`include "chan_cal_params.svh"

module cal_correct
   import chan_cal_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire result_s raw,
   input wire logic [23:0] offset_coefficient,
   input wire logic [23:0] gain_coefficient,
   output result_s corrected
);

   logic signed [24:0] diff;
   logic signed [49:0] product;
   logic signed [49:0] scaled;
   logic [23:0] next_data;

   always_comb begin
      // offset first, then gain; 25 bits so the subtraction cannot wrap
      diff = $signed({raw.data[23], raw.data}) -
             $signed({offset_coefficient[23], offset_coefficient});
      product = 50'(diff) * $signed({25'h0000000, gain_coefficient});
      scaled = product >>> `GAIN_FRAC_BITS;
      if (scaled > 50'sh00000007FFFFF) begin
         next_data = 24'h7FFFFF;
      end else if (scaled < -50'sh0000000800000) begin
         next_data = 24'h800000;
      end else begin
         next_data = scaled[23:0];
      end
   end

   // no bypass: default coefficients give unity, so correction is always in the path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         corrected <= '0;
      end else begin
         corrected.valid <= raw.valid;
         if (raw.valid) begin
            corrected.data <= next_data;
         end
      end
   end

endmodule : cal_correct

// File: verilog/chan_cal_params.svh
`ifndef CHAN_CAL_PARAMS_SVH
`define CHAN_CAL_PARAMS_SVH

`define NUM_CHANNELS 4
`define DATA_WIDTH 24
`define PHASE_WIDTH 10
`define MOD_COUNT_WIDTH 14
`define ACC_WIDTH 16
`define OSR_LOG2_MIN 6
`define OSR_SEL_MAX 4'h8
`define OSR_SEL_FIXED_RANGE 4'h4
`define PHASE_LIMIT_FIXED 11'sh200

`define TEST_STEP 5'h11
`define TEST_PERIOD 5'h1E

`define CH_STRIDE_SHIFT 5
`define OFF_SETUP 3'h0
`define OFF_OFFSET_UPPER 3'h1
`define OFF_OFFSET_LOWER 3'h2
`define OFF_GAIN_UPPER 3'h3
`define OFF_GAIN_LOWER 3'h4
`define OFF_RESULT 3'h5
`define ADDR_OSR_SELECT 12'h080
`define ADDR_STATUS 12'h084

`define SETUP_SELECTOR_LSB 0
`define SETUP_PHASE_LSB 16

`define OFFSET_RESET 24'h000000
`define GAIN_RESET 24'h800000
`define OSR_SEL_RESET 4'h4
`define GAIN_FRAC_BITS 23

`endif

// File: verilog/chan_cal_pkg.sv
package chan_cal_pkg;

   typedef enum logic [1:0] {
      SEL_EXTERNAL,
      SEL_TEST_POS,
      SEL_TEST_NEG,
      SEL_SHORTED
   } input_selector_e;

   typedef struct packed {
      logic [9:0] sample_phase_offset;
      input_selector_e input_selector;
   } channel_setup_s;

   typedef struct packed {
      logic valid;
      logic [23:0] data;
   } result_s;

endpackage : chan_cal_pkg

// File: verilog/channel_phase_and_calibration.sv
// How it works
// - two-bit selector routes positive or negative test
// - one shared test source for all channels
// - test level is two fifteenths full scale
// - phase is ten-bit signed modulator cycle count
// - results span OSR samples, aligned at zero
// - phase range is half OSR, capped 512
// - out-of-range phase saturates to nearest limit
// - range doubles per OSR step up to 512
// - phase settings shift at the channel's next window boundary
// - subtract per-channel offset before output
// - offset is signed 24-bit two's complement
// - multiply by per-channel gain before output
// - gain unsigned, step two to minus 23
// - per-channel coefficients split upper and lower
// - offset resets zero, gain resets unity
// - correction always active, no enable
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "chan_cal_params.svh"

module channel_phase_and_calibration
   import chan_cal_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mod_tick,
   input wire logic [3:0] mod_bits,
   output logic [3:0] result_strobe,
   output logic result_ready_n
);

   localparam int NCH = `NUM_CHANNELS;

   // access codes of reg_decode
   localparam logic [3:0] ACC_SETUP = 4'h0;
   localparam logic [3:0] ACC_OFFSET_UPPER = 4'h1;
   localparam logic [3:0] ACC_OFFSET_LOWER = 4'h2;
   localparam logic [3:0] ACC_GAIN_UPPER = 4'h3;
   localparam logic [3:0] ACC_GAIN_LOWER = 4'h4;
   localparam logic [3:0] ACC_RESULT = 4'h5;
   localparam logic [3:0] ACC_OSR = 4'h6;
   localparam logic [3:0] ACC_STATUS = 4'h7;
   localparam logic [3:0] ACC_NONE = 4'h8;

   channel_setup_s channel_setup [NCH];
   logic [23:0] offset_coefficient [NCH];
   logic [23:0] gain_coefficient [NCH];
   logic [23:0] result [NCH];
   logic [3:0] osr_select;
   logic [3:0] fresh;
   logic [13:0] mod_count;
   logic [4:0] test_acc;
   logic test_bit;
   logic status_read;
   logic [3:0] new_result;
   logic [5:0] test_sum;
   logic [3:0] next_fresh;

   // decoded access: code 0..5 per channel, 6 osr, 7 status, 8 unmapped
   function automatic logic [3:0] reg_decode(input logic [11:0] addr);
      logic [3:0] code;
      code = ACC_NONE;
      if (addr == `ADDR_OSR_SELECT) begin
         code = ACC_OSR;
      end else if (addr == `ADDR_STATUS) begin
         code = ACC_STATUS;
      end else if (addr[11:7] == 5'h00 && addr[1:0] == 2'h0 && addr[4:2] <= `OFF_RESULT) begin
         code = {1'b0, addr[4:2]};
      end
      return code;
   endfunction : reg_decode

   function automatic logic [3:0] osr_clamp(input logic [3:0] sel);
      return (sel > `OSR_SEL_MAX) ? `OSR_SEL_MAX : sel;
   endfunction : osr_clamp

   function automatic logic [13:0] window_mask(input logic [3:0] sel);
      logic [4:0] lg;
      lg = 5'(`OSR_LOG2_MIN) + {1'b0, osr_clamp(sel)};
      return 14'((15'h0001 << lg) - 15'h0001);
   endfunction : window_mask

   // the cap keeps the ten-bit field usable above OSR 1024
   function automatic logic signed [9:0] clip_phase(input logic [9:0] raw,
                                                    input logic [3:0] sel);
      logic signed [10:0] limit;
      logic signed [10:0] value;
      logic signed [9:0] clipped;
      if (osr_clamp(sel) > `OSR_SEL_FIXED_RANGE) begin
         limit = 11'(`PHASE_LIMIT_FIXED);
      end else begin
         limit = 11'sh020 <<< osr_clamp(sel);
      end
      value = 11'($signed(raw));
      if (value > limit - 11'sh001) begin
         clipped = 10'(limit - 11'sh001);
      end else if (value < -limit) begin
         clipped = 10'(-limit);
      end else begin
         clipped = raw;
      end
      return clipped;
   endfunction : clip_phase

   // ---------------- APB slave, zero wait state ----------------
   logic setup_phase;
   logic access_phase;
   logic [3:0] decode;
   logic [1:0] ch_sel;

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;
   assign decode = reg_decode(paddr);
   assign ch_sel = paddr[6:5];
   // every register answers at once, so no wait states are inserted
   assign pready = 1'b1;
   assign pslverr = access_phase & (decode == ACC_NONE);
   assign status_read = access_phase & ~pwrite & (decode == ACC_STATUS);

   // read data is taken in the setup cycle and stands until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup_phase && !pwrite) begin
         case (decode)
            ACC_SETUP: prdata <= 32'({channel_setup[ch_sel].sample_phase_offset, 14'h0000,
                                      channel_setup[ch_sel].input_selector});
            ACC_OFFSET_UPPER: prdata <= {16'h0000, offset_coefficient[ch_sel][23:8]};
            ACC_OFFSET_LOWER: prdata <= {24'h000000, offset_coefficient[ch_sel][7:0]};
            ACC_GAIN_UPPER: prdata <= {16'h0000, gain_coefficient[ch_sel][23:8]};
            ACC_GAIN_LOWER: prdata <= {24'h000000, gain_coefficient[ch_sel][7:0]};
            ACC_RESULT: prdata <= {{8{result[ch_sel][23]}}, result[ch_sel]};
            ACC_OSR: prdata <= {28'h0000000, osr_select};
            ACC_STATUS: prdata <= {27'h0000000, ~result_ready_n, fresh};
            default: prdata <= '0;
         endcase
      end
   end

   // a new ratio takes hold at once; the windows restart on it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osr_select <= `OSR_SEL_RESET;
      end else if (access_phase && pwrite && (decode == ACC_OSR)) begin
         osr_select <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            channel_setup[i] <= '0;
         end
      end else if (access_phase && pwrite && (decode == ACC_SETUP)) begin
         channel_setup[ch_sel].input_selector <= input_selector_e'(pwdata[1:0]);
         channel_setup[ch_sel].sample_phase_offset <= pwdata[25:16];
      end
   end

   // halves land one at a time, so a mixed word stands between the two writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NCH; i++) begin
            offset_coefficient[i] <= `OFFSET_RESET;
            gain_coefficient[i] <= `GAIN_RESET;
         end
      end else if (access_phase && pwrite) begin
         case (decode)
            ACC_OFFSET_UPPER: offset_coefficient[ch_sel][23:8] <= pwdata[15:0];
            ACC_OFFSET_LOWER: offset_coefficient[ch_sel][7:0] <= pwdata[7:0];
            ACC_GAIN_UPPER: gain_coefficient[ch_sel][23:8] <= pwdata[15:0];
            ACC_GAIN_LOWER: gain_coefficient[ch_sel][7:0] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ---------------- modulator timebase ----------------
   // 14-bit count wraps at 16384, a multiple of every OSR, so windows stay aligned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_count <= '0;
      end else if (mod_tick) begin
         mod_count <= mod_count + 14'h0001;
      end
   end

   // shared test source: ones density 17/30 gives a mean of 2/15 of full scale,
   // independent of any gain since it is applied after the front end
   // one bit wider so the step can never wrap before the compare
   assign test_sum = {1'b0, test_acc} + {1'b0, `TEST_STEP};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_acc <= '0;
         test_bit <= 1'b0;
      end else if (mod_tick) begin
         if (test_sum >= {1'b0, `TEST_PERIOD}) begin
            test_acc <= 5'(test_sum - {1'b0, `TEST_PERIOD});
            test_bit <= 1'b1;
         end else begin
            test_acc <= test_sum[4:0];
            test_bit <= 1'b0;
         end
      end
   end

   // ---------------- per-channel decimation and correction ----------------
   logic [3:0] osr_prev;
   logic osr_changed;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osr_prev <= `OSR_SEL_RESET;
      end else begin
         osr_prev <= osr_select;
      end
   end

   // a ratio change restarts every window, as the old count no longer fits
   assign osr_changed = (osr_prev != osr_select);

   generate
      for (genvar c = 0; c < NCH; c++) begin : g_chan
         logic signed [9:0] active_phase;
         logic signed [9:0] target_phase;
         logic signed [1:0] sample;
         logic signed [15:0] acc;
         logic signed [39:0] scaled;
         logic synced;
         logic boundary;
         result_s raw;
         result_s corrected;

         assign target_phase = clip_phase(channel_setup[c].sample_phase_offset, osr_select);
         assign boundary = mod_tick &&
            (((mod_count - 14'($signed(active_phase))) & window_mask(osr_select)) == 14'h0000);

         always_comb begin
            case (channel_setup[c].input_selector)
               SEL_EXTERNAL: sample = mod_bits[c] ? 2'sb01 : 2'sb11;
               SEL_TEST_POS: sample = test_bit ? 2'sb01 : 2'sb11;
               SEL_TEST_NEG: sample = test_bit ? 2'sb11 : 2'sb01;
               SEL_SHORTED: sample = 2'sb00;
               default: sample = 2'sb00;
            endcase
         end

         always_comb begin
            scaled = 40'(acc) <<< (5'd17 - {1'b0, osr_clamp(osr_select)});
            raw.valid = boundary & synced;
            if (scaled > 40'sh00007FFFFF) begin
               raw.data = 24'h7FFFFF;
            end else if (scaled < -40'sh0000800000) begin
               raw.data = 24'h800000;
            end else begin
               raw.data = scaled[23:0];
            end
         end

         // a phase step discards the partial window so no result mixes alignments
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               active_phase <= '0;
               acc <= '0;
               synced <= 1'b0;
            end else if (osr_changed) begin
               synced <= 1'b0;
               acc <= '0;
            end else if (boundary) begin
               acc <= 16'(sample);
               if (target_phase != active_phase) begin
                  active_phase <= target_phase;
                  synced <= 1'b0;
               end else begin
                  synced <= 1'b1;
               end
            end else if (mod_tick) begin
               acc <= acc + 16'(sample);
            end
         end

         cal_correct u_correct (
            .pclk(pclk),
            .presetn(presetn),
            .raw(raw),
            .offset_coefficient(offset_coefficient[c]),
            .gain_coefficient(gain_coefficient[c]),
            .corrected(corrected)
         );

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               result[c] <= '0;
            end else if (corrected.valid) begin
               result[c] <= corrected.data;
            end
         end

         assign new_result[c] = corrected.valid;
      end
   endgenerate

   // ready follows the last channel to finish, so phase moves its timing
   assign next_fresh = new_result | (fresh & {4{~status_read}});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh <= '0;
      end else begin
         fresh <= next_fresh;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_ready_n <= 1'b1;
      end else begin
         result_ready_n <= ~&next_fresh;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_strobe <= '0;
      end else begin
         result_strobe <= new_result;
      end
   end

endmodule : channel_phase_and_calibration
